// ---- rtl/asp_cfg.svh ----
// Constants, register map and timing of the dual asynchronous serial port
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// ---------------------------------------------------------------
// Sizes and timing
// ---------------------------------------------------------------
`define ASP_NPORT 2
`define ASP_DEPTH 16
`define ASP_LVL_W 5
`define ASP_DIV_W 16
`define ASP_CLK_HZ 125000000
`define ASP_MAX_BPS 3000000
`define ASP_OVS 16
`define ASP_MIN_DIV ((`ASP_CLK_HZ + `ASP_OVS * `ASP_MAX_BPS - 1) / (`ASP_OVS * `ASP_MAX_BPS))
`define ASP_TICK_MID 4'h7
`define ASP_TICK_LAST 4'hF
`define ASP_MIN_BITS 4'h5
`define ASP_LINE_IDLE 1'b1

// ---------------------------------------------------------------
// Register map, byte offsets within a port
// ---------------------------------------------------------------
`define ASP_CH_BIT 5
`define ASP_OFS_W 5
`define ASP_OFS_DATA 5'h00
`define ASP_OFS_STAT 5'h04
`define ASP_OFS_CTRL 5'h08
`define ASP_OFS_LCR 5'h0C
`define ASP_OFS_BAUD 5'h10
`define ASP_OFS_IFLS 5'h14
`define ASP_OFS_RIS 5'h18
`define ASP_OFS_IMSK 5'h1C

// ---------------------------------------------------------------
// Reset values and trigger fractions in eighths
// ---------------------------------------------------------------
`define ASP_CTRL_RST 8'h02
`define ASP_LCR_RST 6'h03
`define ASP_BAUD_RST 16'h0044
`define ASP_IFLS_RST 6'h12
`define ASP_IMSK_RST 7'h00
`define ASP_TSEL_1_8 3'h0
`define ASP_TSEL_1_4 3'h1
`define ASP_TSEL_1_2 3'h2
`define ASP_TSEL_3_4 3'h3
`define ASP_TM_1_8 3'h1
`define ASP_TM_1_4 3'h2
`define ASP_TM_1_2 3'h4
`define ASP_TM_3_4 3'h6
`define ASP_TM_7_8 3'h7
`define ASP_TM_SH 3

`endif

// ---- rtl/asp_pkg.sv ----
// Shared types of the dual asynchronous serial port
`include "asp_cfg.svh"
`default_nettype none
package asp_pkg;
  typedef struct packed {
    logic loop; logic rx_dma; logic tx_dma; logic cts_en;
    logic rts_en; logic brk; logic fifo_en; logic en;
  } asp_ctrl_t;
  typedef struct packed {
    logic stop2; logic stick; logic even; logic pen; logic [1:0] wlen;
  } asp_lcr_t;
  typedef struct packed {logic [2:0] rx_sel; logic [2:0] tx_sel;} asp_ifls_t;
  typedef struct packed {
    logic brk; logic pe; logic fe; logic oe; logic eot; logic tx; logic rx;
  } asp_irq_t;
  typedef struct packed {logic brk; logic pe; logic fe; logic [7:0] data;} asp_rxw_t;
  typedef struct packed {
    logic rx_burst; logic rx_single; logic tx_burst; logic tx_single;
  } asp_dma_t;
  typedef struct packed {
    logic [`ASP_LVL_W-1:0] rx_lvl; logic [`ASP_LVL_W-1:0] tx_lvl;
    logic rx_full; logic rx_empty; logic tx_full; logic tx_empty;
    logic tx_busy; logic rx_busy;
  } asp_stat_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_START = 5'h02, ST_DATA = 5'h04, ST_PAR = 5'h08, ST_STOP = 5'h10
  } asp_st_t;
endpackage
`default_nettype wire

// ---- rtl/asp_fifo.sv ----
// Flip-flop FIFO with run-time depth limit of one entry
`include "asp_cfg.svh"
`default_nettype none
module asp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = `ASP_DEPTH,
  parameter int LW = `ASP_LVL_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic flush,
  input wire logic one_deep,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [LW-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH >= (1 << LW)) begin : g_chk
    $error("asp_fifo: DEPTH must be a power of two that LW bits can count");
  end
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [LW-1:0] cnt_r;
  wire logic [LW-1:0] cap = one_deep ? LW'(1) : LW'(DEPTH);
  wire logic do_wr = in_valid & in_ready;
  wire logic do_rd = out_valid & out_ready;

  assign in_ready = cnt_r < cap;
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  assign level = cnt_r;

  always_ff @(posedge sys_clk) begin
    if (do_wr) mem_r[wp_r] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + AW'(1);
      if (do_rd) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + LW'(do_wr) - LW'(do_rd);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/asp_baud.sv ----
// Oversampling baud tick divider running off the system clock
`include "asp_cfg.svh"
`default_nettype none
module asp_baud #(
  parameter int DW = `ASP_DIV_W,
  parameter int MIN_DIV = `ASP_MIN_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic [DW-1:0] divisor,
  input wire logic run,
  // Tick out, one cycle every divisor cycles, or every MIN_DIV cycles if divisor is smaller
  output logic tick
);
  logic [DW-1:0] cnt_r;
  logic tick_r;
  if (MIN_DIV < 1 || MIN_DIV >= (1 << DW)) begin : g_chk
    $error("asp_baud: MIN_DIV must fit the divider width");
  end
  // Clamp keeps the line at or below the top rate
  wire logic [DW-1:0] lim = (divisor < DW'(MIN_DIV)) ? DW'(MIN_DIV) : divisor;

  assign tick = tick_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= (!run || cnt_r == '0) ? lim - DW'(1) : cnt_r - DW'(1);
      tick_r <= run && cnt_r == '0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/asp_top.sv ----
// Dual asynchronous serial port with FIFOs, DMA requests and interrupts
`include "asp_cfg.svh"
`default_nettype none
module asp_top
  import asp_pkg::*;
#(
  parameter int DEPTH = `ASP_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [`ASP_CH_BIT:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Serial lines
  output logic [`ASP_NPORT-1:0] txd,
  input wire logic [`ASP_NPORT-1:0] rxd,
  output logic [`ASP_NPORT-1:0] rts_n,
  input wire logic [`ASP_NPORT-1:0] cts_n,
  // Interrupts and DMA requests
  output logic [`ASP_NPORT-1:0] irq,
  output asp_dma_t [`ASP_NPORT-1:0] dma_req
);
  localparam int LW = `ASP_LVL_W;
  localparam int CW = $bits(asp_ctrl_t);
  localparam int LCW = $bits(asp_lcr_t);
  localparam int FW = $bits(asp_ifls_t);
  localparam int IW = $bits(asp_irq_t);
  localparam int RW = $bits(asp_rxw_t);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (DEPTH < 2 || DEPTH > (1 << (LW - 1)) || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("asp_top: DEPTH must be a power of two from 2 to 16");
  end

  // ---------------------------------------------------------------
  // Shared decoding
  // ---------------------------------------------------------------
  function automatic logic [3:0] nbits(asp_lcr_t l);
    return `ASP_MIN_BITS + 4'(l.wlen);
  endfunction

  function automatic logic [7:0] wmask(asp_lcr_t l);
    return 8'hFF >> (~l.wlen);
  endfunction

  function automatic logic par_bit(logic [7:0] d, asp_lcr_t l);
    logic p;
    p = ^(d & wmask(l));
    if (l.stick) return ~l.even;
    return l.even ? p : ~p;
  endfunction

  // Threshold in entries; the receive one never drops below one entry
  function automatic logic [LW-1:0] trig(logic [2:0] sel, logic one, logic rx);
    logic [LW+2:0] m;
    logic [LW+2:0] d;
    logic [LW-1:0] t;
    case (sel)
      `ASP_TSEL_1_8: m = (LW+3)'(`ASP_TM_1_8);
      `ASP_TSEL_1_4: m = (LW+3)'(`ASP_TM_1_4);
      `ASP_TSEL_1_2: m = (LW+3)'(`ASP_TM_1_2);
      `ASP_TSEL_3_4: m = (LW+3)'(`ASP_TM_3_4);
      default: m = (LW+3)'(`ASP_TM_7_8);
    endcase
    d = one ? (LW+3)'(1) : (LW+3)'(DEPTH);
    t = LW'((d * m) >> `ASP_TM_SH);
    if (rx && t == '0) t = LW'(1);
    return t;
  endfunction

  wire logic [`ASP_OFS_W-1:0] off = reg_addr[`ASP_OFS_W-1:0];
  wire logic psel = reg_addr[`ASP_CH_BIT];
  wire asp_ctrl_t wctrl = asp_ctrl_t'(reg_wdata[CW-1:0]);
  logic [31:0] ch_rd [`ASP_NPORT];
  logic [31:0] rdata_r;

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Read data, valid only in the cycle after the read strobe
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rdata_r <= '0;
    else rdata_r <= reg_rd ? ch_rd[psel] : '0;
  end

  // ---------------------------------------------------------------
  // One complete port per instance
  // ---------------------------------------------------------------
  for (genvar i = 0; i < `ASP_NPORT; i++) begin : g_ch
    asp_ctrl_t ctrl_r;
    asp_lcr_t lcr_r;
    asp_ifls_t ifls_r;
    logic [`ASP_DIV_W-1:0] baud_r;
    logic [IW-1:0] ris_r;
    logic [IW-1:0] imsk_r;
    asp_st_t tst_r;
    asp_st_t tst_nxt;
    asp_st_t rst_r;
    asp_st_t rst_nxt;
    logic [3:0] tcnt_r;
    logic [2:0] tbit_r;
    logic [7:0] tsh_r;
    logic tpar_r;
    logic tstop_r;
    logic txd_r;
    logic rts_n_r;
    logic [3:0] rcnt_r;
    logic [2:0] rbit_r;
    logic [7:0] rsh_r;
    logic rpar_r;
    logic rarm_r;
    logic tick;
    logic tx_go;
    logic r_done;
    logic txf_rdy;
    logic txf_vld;
    logic [7:0] txf_dout;
    logic [LW-1:0] txf_lvl;
    logic rxf_rdy;
    logic rxf_vld;
    asp_rxw_t rxf_dout;
    logic [LW-1:0] rxf_lvl;
    asp_irq_t ev;
    asp_rxw_t rxw;
    asp_stat_t stat;

    // -------------------------------------------------------------
    // Register strobes
    // -------------------------------------------------------------
    wire logic hit = psel == 1'(i);
    wire logic wr_data = reg_wr & hit & (off == `ASP_OFS_DATA);
    wire logic rd_data = reg_rd & hit & (off == `ASP_OFS_DATA);
    wire logic wr_ctrl = reg_wr & hit & (off == `ASP_OFS_CTRL);
    wire logic wr_lcr = reg_wr & hit & (off == `ASP_OFS_LCR);
    wire logic wr_baud = reg_wr & hit & (off == `ASP_OFS_BAUD);
    wire logic wr_ifls = reg_wr & hit & (off == `ASP_OFS_IFLS);
    wire logic wr_ris = reg_wr & hit & (off == `ASP_OFS_RIS);
    wire logic wr_imsk = reg_wr & hit & (off == `ASP_OFS_IMSK);
    // Changing the FIFO mode empties both FIFOs
    wire logic fifo_flush = wr_ctrl & (wctrl.fifo_en != ctrl_r.fifo_en);

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ctrl_r <= asp_ctrl_t'(`ASP_CTRL_RST);
        lcr_r <= asp_lcr_t'(`ASP_LCR_RST);
        baud_r <= `ASP_BAUD_RST;
        ifls_r <= asp_ifls_t'(`ASP_IFLS_RST);
        imsk_r <= `ASP_IMSK_RST;
      end else begin
        if (wr_ctrl) ctrl_r <= wctrl;
        if (wr_lcr) lcr_r <= asp_lcr_t'(reg_wdata[LCW-1:0]);
        if (wr_baud) baud_r <= reg_wdata[`ASP_DIV_W-1:0];
        if (wr_ifls) ifls_r <= asp_ifls_t'(reg_wdata[FW-1:0]);
        if (wr_imsk) imsk_r <= reg_wdata[IW-1:0];
      end
    end

    // -------------------------------------------------------------
    // Baud tick and FIFOs
    // -------------------------------------------------------------
    asp_baud u_baud (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .divisor(baud_r),
      .run(ctrl_r.en),
      .tick(tick)
    );

    // Writes to a full FIFO are dropped; status shows full
    asp_fifo #(.W(8), .DEPTH(DEPTH), .LW(LW)) u_txf (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .flush(fifo_flush),
      .one_deep(!ctrl_r.fifo_en),
      .in_valid(wr_data),
      .in_ready(txf_rdy),
      .in_data(reg_wdata[7:0]),
      .out_valid(txf_vld),
      .out_ready(tx_go),
      .out_data(txf_dout),
      .level(txf_lvl)
    );

    asp_fifo #(.W(RW), .DEPTH(DEPTH), .LW(LW)) u_rxf (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .flush(fifo_flush),
      .one_deep(!ctrl_r.fifo_en),
      .in_valid(r_done),
      .in_ready(rxf_rdy),
      .in_data(rxw),
      .out_valid(rxf_vld),
      .out_ready(rd_data),
      .out_data(rxf_dout),
      .level(rxf_lvl)
    );

    // -------------------------------------------------------------
    // Transmitter
    // -------------------------------------------------------------
    wire logic t_end = tick & (tcnt_r == `ASP_TICK_LAST);
    wire logic t_last = 4'(tbit_r) == nbits(lcr_r) - 4'h1;
    wire logic cts_ok = !(ctrl_r.cts_en & cts_n[i]);
    // A frame already started runs to its end even if CTS drops
    assign tx_go = (tst_r == ST_IDLE) & ctrl_r.en & txf_vld & cts_ok & !ctrl_r.brk;
    wire logic tx_eot = t_end & (tst_r == ST_STOP) & (tst_nxt == ST_IDLE) & !txf_vld;
    wire logic tx_line = ctrl_r.brk ? 1'b0 :
      (tst_r == ST_START) ? 1'b0 :
      (tst_r == ST_DATA) ? tsh_r[0] :
      (tst_r == ST_PAR) ? tpar_r : `ASP_LINE_IDLE;

    always_comb begin
      tst_nxt = tst_r;
      unique case (tst_r)
        ST_IDLE: if (tx_go) tst_nxt = ST_START;
        ST_START: if (t_end) tst_nxt = ST_DATA;
        ST_DATA: if (t_end & t_last) tst_nxt = lcr_r.pen ? ST_PAR : ST_STOP;
        ST_PAR: if (t_end) tst_nxt = ST_STOP;
        ST_STOP: if (t_end & (tstop_r | !lcr_r.stop2)) tst_nxt = ST_IDLE;
        default: tst_nxt = ST_IDLE;
      endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        tst_r <= ST_IDLE;
        tcnt_r <= '0;
        tbit_r <= '0;
        tsh_r <= '0;
        tpar_r <= 1'b0;
        tstop_r <= 1'b0;
        txd_r <= `ASP_LINE_IDLE;
      end else begin
        tst_r <= tst_nxt;
        txd_r <= tx_line;
        if (tx_go) begin
          tcnt_r <= '0;
          tbit_r <= '0;
          tsh_r <= txf_dout;
          tpar_r <= par_bit(txf_dout, lcr_r);
          tstop_r <= 1'b0;
        end else begin
          if (tick) tcnt_r <= tcnt_r + 4'h1;
          if (t_end & (tst_r == ST_DATA)) begin
            tsh_r <= tsh_r >> 1;
            tbit_r <= tbit_r + 3'h1;
          end
          if (t_end & (tst_r == ST_STOP)) tstop_r <= 1'b1;
        end
      end
    end

    // -------------------------------------------------------------
    // Receiver
    // -------------------------------------------------------------
    // Loopback feeds the own transmitter back for self test
    wire logic rx_in = ctrl_r.loop ? txd_r : rxd[i];
    wire logic r_mid = tick & (rcnt_r == `ASP_TICK_MID);
    wire logic r_end = tick & (rcnt_r == `ASP_TICK_LAST);
    wire logic r_last = 4'(rbit_r) == nbits(lcr_r) - 4'h1;
    // Armed only after the line was seen high, so a held break is one event
    wire logic rx_go = (rst_r == ST_IDLE) & ctrl_r.en & rarm_r & !rx_in;
    assign r_done = r_end & (rst_r == ST_STOP);
    wire logic [7:0] r_data = rsh_r >> (~lcr_r.wlen);
    wire logic r_fe = !rx_in;
    wire logic r_pe = lcr_r.pen & (rpar_r != par_bit(r_data, lcr_r));
    wire logic r_brk = r_fe & (r_data == 8'h00) & !(lcr_r.pen & rpar_r);

    assign rxw = '{brk: r_brk, pe: r_pe, fe: r_fe, data: r_data};

    always_comb begin
      rst_nxt = rst_r;
      unique case (rst_r)
        ST_IDLE: if (rx_go) rst_nxt = ST_START;
        ST_START: if (r_mid) rst_nxt = rx_in ? ST_IDLE : ST_DATA;
        ST_DATA: if (r_end & r_last) rst_nxt = lcr_r.pen ? ST_PAR : ST_STOP;
        ST_PAR: if (r_end) rst_nxt = ST_STOP;
        ST_STOP: if (r_end) rst_nxt = ST_IDLE;
        default: rst_nxt = ST_IDLE;
      endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        rst_r <= ST_IDLE;
        rcnt_r <= '0;
        rbit_r <= '0;
        rsh_r <= '0;
        rpar_r <= 1'b0;
        rarm_r <= 1'b0;
      end else begin
        rst_r <= rst_nxt;
        if (rx_go | (r_mid & (rst_r == ST_START))) rcnt_r <= '0;
        else if (tick) rcnt_r <= rcnt_r + 4'h1;
        if (rx_go) rbit_r <= '0;
        else if (r_end & (rst_r == ST_DATA)) begin
          rsh_r <= {rx_in, rsh_r[7:1]};
          rbit_r <= rbit_r + 3'h1;
        end
        if (r_end & (rst_r == ST_PAR)) rpar_r <= rx_in;
        if (r_done & r_fe) rarm_r <= 1'b0;
        else if (rx_in) rarm_r <= 1'b1;
      end
    end

    // -------------------------------------------------------------
    // Flow control, interrupts, DMA
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) rts_n_r <= `ASP_LINE_IDLE;
      else rts_n_r <= ctrl_r.rts_en & !rxf_rdy;
    end

    wire logic [LW-1:0] rx_thr = trig(ifls_r.rx_sel, !ctrl_r.fifo_en, 1'b1);
    wire logic [LW-1:0] tx_thr = trig(ifls_r.tx_sel, !ctrl_r.fifo_en, 1'b0);
    wire logic rx_hit = rxf_lvl >= rx_thr;
    wire logic tx_hit = txf_lvl <= tx_thr;
    assign ev = '{
      brk: r_done & r_brk,
      pe: r_done & r_pe,
      fe: r_done & r_fe,
      oe: r_done & !rxf_rdy,
      eot: tx_eot,
      tx: tx_hit,
      rx: rx_hit
    };

    // A new event in the clearing cycle keeps its bit set
    wire logic [IW-1:0] ris_nxt = (ris_r & ~(wr_ris ? reg_wdata[IW-1:0] : '0)) | ev;
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) ris_r <= '0;
      else ris_r <= ris_nxt;
    end

    assign irq[i] = |(ris_r & imsk_r);
    assign txd[i] = txd_r;
    assign rts_n[i] = rts_n_r;

    assign dma_req[i] = '{
      rx_burst: ctrl_r.rx_dma & rx_hit,
      rx_single: ctrl_r.rx_dma & rxf_vld,
      tx_burst: ctrl_r.tx_dma & tx_hit,
      tx_single: ctrl_r.tx_dma & txf_rdy
    };

    // -------------------------------------------------------------
    // Read selection
    // -------------------------------------------------------------
    assign stat = '{
      rx_lvl: rxf_lvl,
      tx_lvl: txf_lvl,
      rx_full: !rxf_rdy,
      rx_empty: !rxf_vld,
      tx_full: !txf_rdy,
      tx_empty: !txf_vld,
      tx_busy: tst_r != ST_IDLE,
      rx_busy: rst_r != ST_IDLE
    };

    assign ch_rd[i] =
      (off == `ASP_OFS_DATA) ? (rxf_vld ? 32'(rxf_dout) : '0) :
      (off == `ASP_OFS_STAT) ? 32'(stat) :
      (off == `ASP_OFS_CTRL) ? 32'(ctrl_r) :
      (off == `ASP_OFS_LCR) ? 32'(lcr_r) :
      (off == `ASP_OFS_BAUD) ? 32'(baud_r) :
      (off == `ASP_OFS_IFLS) ? 32'(ifls_r) :
      (off == `ASP_OFS_RIS) ? 32'(ris_r) :
      (off == `ASP_OFS_IMSK) ? 32'(imsk_r) : '0;
  end
endmodule
`default_nettype wire

// ---- tb/asp_asserts.sv ----
// Port checker for the dual serial port
`include "asp_cfg.svh"
`default_nettype none
module asp_asserts
  import asp_pkg::*;
#(parameter int DEPTH = 16) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register port
  input wire logic [`ASP_CH_BIT:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Serial lines
  input wire logic [`ASP_NPORT-1:0] txd,
  input wire logic [`ASP_NPORT-1:0] rxd,
  input wire logic [`ASP_NPORT-1:0] rts_n,
  input wire logic [`ASP_NPORT-1:0] cts_n,
  // Interrupts and DMA
  input wire logic [`ASP_NPORT-1:0] irq,
  input wire asp_dma_t [`ASP_NPORT-1:0] dma_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Run length of txd levels, saturating
  // ------
  logic prev_r;
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  wire logic edge_w;
  assign edge_w = txd[0] != prev_r;
  assign run_nxt = edge_w ? 8'h01 : (&run_r ? run_r : run_r + 8'h01);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= 1'b1;
      run_r <= 8'h00;
    end else begin
      prev_r <= txd[0];
      run_r <= run_nxt;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_bit_len;
    edge_w |-> run_r >= 8'h28;
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("short bit on txd");
  property p_rxb;
    dma_req[0].rx_burst |-> dma_req[0].rx_single;
  endproperty
  a_rxb: assert property (p_rxb) else $error("rx burst without single");
  property p_txb;
    dma_req[0].tx_burst |-> dma_req[0].tx_single;
  endproperty
  a_txb: assert property (p_txb) else $error("tx burst without single");
  property p_rx_drop;
    $fell(dma_req[0].rx_single) |-> $past(reg_rd || reg_wr) && !$past(reg_addr[5]);
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx request dropped alone");
  property p_tx_fill;
    $fell(dma_req[0].tx_single) |-> $past(reg_wr) && !$past(reg_addr[5]);
  endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("tx request dropped alone");
  property p_irq_mask;
    reg_wr && reg_addr == {1'b0, `ASP_OFS_IMSK} && reg_wdata[6:0] == 7'h00 |=> !irq[0];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all masked");
  property p_irq_clr;
    $fell(irq[0]) |-> $past(reg_wr) && !$past(reg_addr[5]);
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq fell without write");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
  c_irq: cover property ($rose(irq[0]));
  c_full: cover property ($fell(dma_req[0].tx_single));
  c_rxb: cover property (dma_req[0].rx_burst);
endmodule
bind asp_top asp_asserts #(.DEPTH(DEPTH)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n), .irq(irq),
  .dma_req(dma_req));
`default_nettype wire

// ---- tb/asp_peer.sv ----
// Remote serial peer: frame sender and decoder for port 0
`default_nettype none
module asp_peer (
  // Clock
  input wire logic clk,
  // Serial lines
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 48;
  int nb = 8;
  int pen = 0;
  int sb = 1;
  int rxq[$];
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  // Failed stop bits push -1 so the bench sees a mismatch
  always begin
    int v;
    bit ok;
    @(negedge txd);
    repeat (BT / 2) @(posedge clk);
    v = 0;
    ok = !txd;
    for (int i = 0; i < nb + pen; i++) begin
      repeat (BT) @(posedge clk);
      v[i] = txd;
    end
    for (int i = 0; i < sb; i++) begin
      repeat (BT) @(posedge clk);
      ok &= txd;
    end
    rxq.push_back(ok ? v : -1);
  end
  task automatic send(input int d, input int p);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BT) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (BT) @(posedge clk);
    end
    if (pen) begin
      rxd <= p[0];
      repeat (BT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BT * sb) @(posedge clk);
  endtask
  task automatic brk();
    @(posedge clk);
    rxd <= 1'b0;
    repeat (BT * 12) @(posedge clk);
    rxd <= 1'b1;
    repeat (BT * 2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the dual serial port
`include "asp_cfg.svh"
`default_nettype none
module tb_top
  import asp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  `define WAITFOR(c) for (int k = 0; !(c); k++) begin if (k > 40000) begin n_fail++; \
    end_of_test(); end @(posedge sys_clk); end
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [`ASP_CH_BIT:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] txd;
  logic [1:0] rts_n;
  logic [1:0] irq;
  logic prx;
  logic pcts;
  asp_dma_t [1:0] dma_req;
  logic [31:0] lfsr = 32'h7D54;
  logic [31:0] rv;
  int n_fail = 0;
  int n_compared = 0;
  int q[$];
  int d, e, m, bad, nb, pen, ev, stk, sb;
  int ra[6] = '{`ASP_OFS_CTRL, `ASP_OFS_LCR, `ASP_OFS_BAUD, `ASP_OFS_IFLS, `ASP_OFS_IMSK, 2};
  int re[6] = '{`ASP_CTRL_RST, `ASP_LCR_RST, `ASP_BAUD_RST, `ASP_IFLS_RST, `ASP_IMSK_RST, 0};
  always #4 sys_clk = ~sys_clk;
  asp_top #(.DEPTH(16)) dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .txd(txd), .rxd({txd[1], prx}), .rts_n(rts_n), .cts_n({pcts, pcts}), .irq(irq),
    .dma_req(dma_req));
  asp_peer peer (.clk(sys_clk), .txd(txd[0]), .rxd(prx), .cts_n(pcts));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return lfsr;
  endfunction
  function automatic int par(int x);
    return stk ? !ev : (^(x & m)) ^ !ev;
  endfunction
  task automatic wr(input int a, input int v);
    @(posedge sys_clk);
    reg_addr <= a[5:0];
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input int a);
    @(posedge sys_clk);
    reg_addr <= a[5:0];
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rv = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic drain();
    int g;
    while (q.size() > 0) begin
      g = peer.rxq.pop_front();
      e = q.pop_front();
      `CHK(g, e)
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------
  // Stimulus
  // ------
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      `CHK(rv, re[i])
    end
    wr(`ASP_OFS_BAUD, 3);
    wr(`ASP_OFS_IFLS, 2);
    wr(`ASP_OFS_CTRL, 8'h73);
    // Clear-to-send held off: seventeenth byte must be dropped
    for (int i = 0; i < 17; i++) begin
      d = rnd() & 8'hFF;
      if (i < 16) q.push_back(d);
      wr(`ASP_OFS_DATA, d);
    end
    rd(`ASP_OFS_STAT);
    `CHK(rv[10:3], 8'h83)
    `CHK({dma_req[0].tx_burst, dma_req[0].tx_single}, 2'b00)
    `CHK(peer.rxq.size(), 0)
    `CHK({txd[1], irq[1], rts_n, dma_req[1]}, 8'h80)
    rd(32 + `ASP_OFS_CTRL);
    `CHK(rv, `ASP_CTRL_RST)
    peer.cts_n <= 1'b0;
    `WAITFOR(peer.rxq.size() == 16)
    drain();
    `CHK({dma_req[0].tx_burst, dma_req[0].tx_single}, 2'b11)
    wr(`ASP_OFS_IMSK, 4);
    `WAITFOR(irq[0] === 1'b1)
    rd(`ASP_OFS_RIS);
    `CHK(rv[2], 1'b1)
    wr(`ASP_OFS_IMSK, 0);
    #1 `CHK(irq[0], 1'b0)
    wr(`ASP_OFS_RIS, 4);
    wr(`ASP_OFS_IMSK, 4);
    #1 `CHK(irq[0], 1'b0)
    peer.brk();
    rd(`ASP_OFS_DATA);
    `CHK(rv, 32'h500)
    for (int f = 0; f < 5; f++) begin
      nb = 8 - f % 4;
      pen = f > 0;
      ev = f % 2;
      stk = f > 2;
      sb = 1 + (f / 2) % 2;
      m = (1 << nb) - 1;
      peer.nb = nb;
      peer.pen = pen;
      peer.sb = sb;
      wr(`ASP_OFS_LCR, (sb - 1) * 32 + stk * 16 + ev * 8 + pen * 4 + nb - 5);
      repeat (2) begin
        d = rnd() & 8'hFF;
        q.push_back((d & m) | (pen ? par(d) << nb : 0));
        wr(`ASP_OFS_DATA, d);
      end
      `WAITFOR(peer.rxq.size() == 2)
      drain();
      for (int b = 0; b < 2; b++) begin
        d = rnd() & 8'hFF;
        bad = pen && b;
        peer.send(d, par(d) ^ bad);
        q.push_back(bad * 512 + (d & m));
      end
      `CHK({dma_req[0].rx_burst, dma_req[0].rx_single}, 2'b11)
      for (int b = 0; b < 2; b++) begin
        rd(`ASP_OFS_DATA);
        e = q.pop_front();
        `CHK(rv, e)
      end
      `CHK(dma_req[0].rx_single, 1'b0)
    end
    // One-deep mode with RTS: second byte overruns
    wr(`ASP_OFS_CTRL, 8'h79);
    repeat (2) peer.send(8'h5A, 1);
    `CHK({rts_n[0], dma_req[0].rx_burst, dma_req[0].rx_single}, 3'b111)
    rd(`ASP_OFS_RIS);
    `CHK(rv[3], 1'b1)
    rd(`ASP_OFS_DATA);
    `CHK(rv, 32'h5A)
    end_of_test();
  end
endmodule
`default_nettype wire
